// file: common/uoc_map.vh
// Register map, field positions and timing constants of the OTG
// enable/status/control register block.
// Assumes a 32-bit AHB-Lite word bus and a 125 MHz module clock.
`ifndef UOC_MAP_VH
`define UOC_MAP_VH

// Byte offsets of the registers
`define UOC_OFF_FLAG      8'h00
`define UOC_OFF_IRQ_EN    8'h10
`define UOC_OFF_STATUS    8'h20
`define UOC_OFF_CONTROL   8'h30

// Implemented width of every register; upper bits read zero
`define UOC_REG_W         8
`define UOC_RST_VAL       8'h00

// Writable bits of the flag and enable registers (bit 1 absent)
`define UOC_EVT_MASK      8'hfd

// Event / enable bit positions
`define UOC_B_ID          7
`define UOC_B_TMR         6
`define UOC_B_LINE        5
`define UOC_B_ACT         4
`define UOC_B_SESSION_VALID_STATE       3
`define UOC_B_SESSION_END_STATE      2
`define UOC_B_A_VBUS_VALID_STATE      0

// Control bit positions
`define UOC_B_DP_UP       7
`define UOC_B_DM_UP       6
`define UOC_B_DP_DN       5
`define UOC_B_DM_DN       4
`define UOC_B_VBUS_ON     3
`define UOC_B_SW_SEL      2
`define UOC_B_CHG         1
`define UOC_B_DIS         0

// Timing: one millisecond in ns over the clock period in ns
`define UOC_MS_NS         1000000
`define UOC_CLK_NS        8
`define UOC_MS_CYCLES     (`UOC_MS_NS / `UOC_CLK_NS)

// Synchroniser depth for pin inputs
`define UOC_SYNC_STAGES   2

`endif

// file: verilog/uoc_sync.v
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes the inputs are quasi-static levels; no pulse capture.
`timescale 1ns/10ps
`include "uoc_map.vh"

module uoc_sync #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // Pin side
  input  wire [WIDTH-1:0] async_in,
  // Clock side
  output wire [WIDTH-1:0] sync_out
);

  // One pair of flops per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // uoc_sync

// file: verilog/uoc_regs.v
// OTG interrupt-enable, status and control register block with its
// event flags, one millisecond timer and line-state stability watch.
// Assumes an AHB-Lite master with single word transfers and pin
// inputs from the transceiver, cable ID pin and VBUS comparators.
//
// Behaviour
// [R01] Bits 31..8 read zero, writes ignored
// [R02] Enable bit 7 gates cable ID change
// [R03] Enable bit 6 gates millisecond timer expiry
// [R04] Enable bits 5,4 gate line, activity
// [R05] Activity enable read/write, reset zero
// [R06] Enable bits 3,2 gate session events
// [R07] Enable bit 0 VBUS valid; bit1 zero
// [R08] Status bit 7 shows cable ID pin
// [R09] Status bit 5: line stable 1 ms
// [R10] Status bit 3: session valid comparator
// [R11] Status bit 2: session end comparator
// [R12] Status bit 0 VBUS valid; others zero
// [R13] Control bits 7,6 drive pull-ups
// [R14] Control bits 5,4 drive pull-downs
// [R15] Control bit 3 drives VBUS power
// [R16] Bit 2 selects software or hardware pulls
// [R17] Control bits 1,0 charge, discharge VBUS
// [R18] Hardware sets flags, write one clears
// [R19] Line flag: stable, differs from last
// [R20] Interrupt when enabled flag is set
// [R21] Status inputs synchronised to clock
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "uoc_map.vh"

module uoc_regs #(
  parameter MS_CYCLES = `UOC_MS_CYCLES,
  parameter CNT_W     = 17
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Pins and comparators (asynchronous)
  input  wire        cable_id_pin,
  input  wire        line_se0_in,
  input  wire        line_j_indication,
  input  wire        session_valid_in,
  input  wire        session_end_in,
  input  wire        a_vbus_valid_in,
  // Pull requests from the USB hardware (same clock)
  input  wire        hw_dplus_pullup,
  input  wire        hw_dminus_pullup,
  input  wire        hw_dplus_pulldown,
  input  wire        hw_dminus_pulldown,
  // Transceiver and VBUS controls
  output reg         dplus_pullup_en,
  output reg         dminus_pullup_en,
  output reg         dplus_pulldown_en,
  output reg         dminus_pulldown_en,
  output reg         vbus_power_on,
  output reg         vbus_charge_en,
  output reg         vbus_discharge_en,
  // Interrupt request
  output reg         otg_irq
);

  // Synchronised pin levels
  wire [5:0] pin_sync;
  wire       s_id;
  wire       s_se0;
  wire       s_j;
  wire       s_session_valid_state;
  wire       s_session_end_state;
  wire       s_a_vbus_valid_state;

  // Registers
  reg  [7:0] irq_en;
  reg  [7:0] flags;
  reg  [7:0] control;
  reg  [7:0] status;

  // Previous synchronised levels for change detection
  reg  [5:0] pin_prev;

  // Timers
  reg  [CNT_W-1:0] tick_cnt;
  reg              ms_tick;
  reg  [CNT_W-1:0] stab_cnt;
  reg              line_stable_1ms;
  reg  [1:0]       last_stable_line;

  // AHB address phase capture
  reg        ap_write;
  reg  [7:0] ap_addr;
  wire       ap_take;
  wire       dp_write;

  // Event and write decode
  reg  [7:0] evt_set;
  wire [7:0] flag_clr;
  wire [7:0] next_flags;
  wire       line_changed;
  wire       stab_done;
  reg  [7:0] rd_val;

  // [R21] two-flop synchronisers
  uoc_sync #(
    .WIDTH (6)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({cable_id_pin, line_se0_in, line_j_indication,
                session_valid_in, session_end_in, a_vbus_valid_in}),
    .sync_out (pin_sync)
  );

  assign s_id     = pin_sync[5];
  assign s_se0    = pin_sync[4];
  assign s_j      = pin_sync[3];
  assign s_session_valid_state  = pin_sync[2];
  assign s_session_end_state = pin_sync[1];
  assign s_a_vbus_valid_state = pin_sync[0];

  // Address phase is taken only when the bus is ready and selected
  assign ap_take  = hsel & htrans[1] & hready;

  // Remember the address phase; zero wait states, so ready stays high
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0; // Every transfer answers OKAY
      if (ap_take) begin
        ap_write <= hwrite;
        ap_addr  <= haddr[7:0];
      end else if (hready) begin
        ap_write <= 1'b0;
      end
    end
  end

  // Data phase of a write is the cycle after its address phase
  assign dp_write = ap_write;

  // [R18] write one to clear, masked to implemented bits
  assign flag_clr = (dp_write && ap_addr == `UOC_OFF_FLAG) ?
                    (hwdata[7:0] & `UOC_EVT_MASK) : 8'h00;

  // [R18] a set arriving with its clear wins
  assign next_flags = ((flags & ~flag_clr) | evt_set) & `UOC_EVT_MASK;

  // Enable and control registers; hwdata above bit 7 is dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en  <= `UOC_RST_VAL;
      control <= `UOC_RST_VAL;
    end else if (dp_write) begin
      // [R02] enable register, bit 1 forced zero
      if (ap_addr == `UOC_OFF_IRQ_EN) begin
        irq_en <= hwdata[7:0] & `UOC_EVT_MASK;
      end
      // [R01] upper bits ignored on write
      if (ap_addr == `UOC_OFF_CONTROL) begin
        control <= hwdata[7:0];
      end
    end
  end

  // Millisecond timer: free-running one-cycle tick
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= {CNT_W{1'b0}};
      ms_tick  <= 1'b0;
    end else if (tick_cnt == MS_CYCLES - 1) begin
      tick_cnt <= {CNT_W{1'b0}};
      ms_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      ms_tick  <= 1'b0;
    end
  end

  // Line-state watch: any change of SE0 or J restarts the count
  assign line_changed = (s_se0 != pin_prev[4]) | (s_j != pin_prev[3]);
  assign stab_done    = (stab_cnt == MS_CYCLES - 1);

  // [R09] stable only after a full millisecond unchanged
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stab_cnt         <= {CNT_W{1'b0}};
      line_stable_1ms  <= 1'b0;
      last_stable_line <= 2'h0;
    end else if (line_changed) begin
      stab_cnt        <= {CNT_W{1'b0}};
      line_stable_1ms <= 1'b0;
    end else if (!stab_done) begin
      stab_cnt <= stab_cnt + 1'b1;
    end else if (!line_stable_1ms) begin
      line_stable_1ms  <= 1'b1;
      last_stable_line <= {s_se0, s_j};
    end
  end

  // Previous synchronised levels
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev <= 6'h00;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  // Hardware events feeding the flags
  always @* begin
    evt_set = 8'h00;
    evt_set[`UOC_B_ID]     = s_id != pin_prev[5];
    evt_set[`UOC_B_TMR]    = ms_tick;
    // [R19] newly stable and unlike last stable state
    evt_set[`UOC_B_LINE]   = stab_done & ~line_stable_1ms & ~line_changed &
                             ({s_se0, s_j} != last_stable_line);
    // Activity is any movement on the watched pins
    evt_set[`UOC_B_ACT]    = pin_sync != pin_prev;
    evt_set[`UOC_B_SESSION_VALID_STATE]  = s_session_valid_state != pin_prev[2];
    evt_set[`UOC_B_SESSION_END_STATE] = s_session_end_state != pin_prev[1];
    evt_set[`UOC_B_A_VBUS_VALID_STATE] = s_a_vbus_valid_state != pin_prev[0];
  end

  // Flag register and status snapshot
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags  <= `UOC_RST_VAL;
      status <= `UOC_RST_VAL;
    end else begin
      flags <= next_flags;
      status <= 8'h00;
      // [R08] cable ID level
      status[`UOC_B_ID]     <= s_id;
      // [R09] line stability
      status[`UOC_B_LINE]   <= line_stable_1ms;
      // [R10] session valid comparator
      status[`UOC_B_SESSION_VALID_STATE]  <= s_session_valid_state;
      // [R11] session end comparator
      status[`UOC_B_SESSION_END_STATE] <= s_session_end_state;
      // [R12] A-device VBUS valid comparator
      status[`UOC_B_A_VBUS_VALID_STATE] <= s_a_vbus_valid_state;
    end
  end

  // [R20] interrupt from enabled flags
  // [R03] timer, [R04] line and activity, [R05] activity enable,
  // [R06] session, [R07] VBUS valid all gate through irq_en
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otg_irq <= 1'b0;
    end else begin
      otg_irq <= |(next_flags & irq_en);
    end
  end

  // Pull, VBUS power, charge and discharge drivers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dplus_pullup_en    <= 1'b0;
      dminus_pullup_en   <= 1'b0;
      dplus_pulldown_en  <= 1'b0;
      dminus_pulldown_en <= 1'b0;
      vbus_power_on      <= 1'b0;
      vbus_charge_en     <= 1'b0;
      vbus_discharge_en  <= 1'b0;
    end else begin
      // [R16] software or hardware pull control
      if (control[`UOC_B_SW_SEL]) begin
        // [R13] software pull-ups
        dplus_pullup_en    <= control[`UOC_B_DP_UP];
        dminus_pullup_en   <= control[`UOC_B_DM_UP];
        // [R14] software pull-downs
        dplus_pulldown_en  <= control[`UOC_B_DP_DN];
        dminus_pulldown_en <= control[`UOC_B_DM_DN];
      end else begin
        dplus_pullup_en    <= hw_dplus_pullup;
        dminus_pullup_en   <= hw_dminus_pullup;
        dplus_pulldown_en  <= hw_dplus_pulldown;
        dminus_pulldown_en <= hw_dminus_pulldown;
      end
      // [R15] VBUS power
      vbus_power_on     <= control[`UOC_B_VBUS_ON];
      // [R17] charge and discharge
      vbus_charge_en    <= control[`UOC_B_CHG];
      vbus_discharge_en <= control[`UOC_B_DIS];
    end
  end

  // Read mux on the address phase address; unmapped reads give zero
  always @* begin
    case (haddr[7:0])
      `UOC_OFF_FLAG:    rd_val = flags;
      `UOC_OFF_IRQ_EN:  rd_val = irq_en;
      `UOC_OFF_STATUS:  rd_val = status;
      `UOC_OFF_CONTROL: rd_val = control;
      default:          rd_val = 8'h00;
    endcase
  end

  // [R01] upper read bits are zero
  // Data is latched at the address phase so it stands in the data phase;
  // a read straight after a write to the same register sees the old value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      hrdata <= {24'h00_0000, rd_val};
    end
  end

endmodule // uoc_regs

// file: dv/uoc_regs_sva.sv
// Port checker for the OTG register block.
// Assumes zero-wait single-word AHB-Lite transfers.
`timescale 1ns/10ps
module uoc_regs_sva (
  // Clock, reset and bus
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Pins seen by the status register
  input wire        cable_id_pin,
  input wire        session_valid_in,
  // Pull requests, controls and interrupt
  input wire        hw_dplus_pullup,
  input wire        hw_dplus_pulldown,
  input wire        dplus_pullup_en,
  input wire        dplus_pulldown_en,
  input wire        vbus_power_on,
  input wire        vbus_charge_en,
  input wire        vbus_discharge_en,
  input wire        otg_irq
);
  reg       wv;
  reg [7:0] wa;
  reg [7:0] en;
  reg [7:0] ctl;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(a);
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
  endsequence
  // Shadows of the enable and control registers, updated in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv <= 1'b0;
      wa <= 8'h00;
      en <= 8'h00;
      ctl <= 8'h00;
    end else begin
      wv <= hsel && htrans[1] && hready && hwrite;
      wa <= haddr[7:0];
      if (wv && wa == 8'h10)
        en <= hwdata[7:0] & 8'hfd;
      if (wv && wa == 8'h30)
        ctl <= hwdata[7:0];
    end
  end
  a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  a_unmapped_zero: assert property (s_rd(8'h44) |=> hrdata == 32'h0) else $error("unmapped read");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_en_readback: assert property (s_rd(8'h10) |=> hrdata[7:0] == $past(en)) else $error("enable read");
  a_ctl_readback: assert property (s_rd(8'h30) |=> hrdata[7:0] == $past(ctl)) else $error("control read");
  a_stat_unused: assert property (s_rd(8'h20) |=> (hrdata[7:0] & 8'h52) == 8'h0) else $error("status gap");
  // Status lags a pin by two sync flops, the snapshot and the read capture
  a_id_status: assert property (s_rd(8'h20) |=> hrdata[7] == $past(cable_id_pin, 4)) else $error("id status");
  a_sync_delay: assert property (s_rd(8'h20) |=> hrdata[3] == $past(session_valid_in, 4)) else $error("sync");
  a_pull_mux: assert property ({dplus_pullup_en, dplus_pulldown_en} ==
    $past(ctl[2] ? {ctl[7], ctl[5]} : {hw_dplus_pullup, hw_dplus_pulldown})) else $error("pull select");
  a_vbus_power: assert property (vbus_power_on == $past(ctl[3])) else $error("vbus power");
  a_vbus_chg_dis: assert property ({vbus_charge_en, vbus_discharge_en} == $past(ctl[1:0])) else $error("vbus rc");
  a_irq_gated: assert property (otg_irq |-> $past(en) != 8'h00) else $error("irq without enable");
endmodule // uoc_regs_sva

bind uoc_regs uoc_regs_sva uoc_regs_sva_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cable_id_pin(cable_id_pin), .session_valid_in(session_valid_in),
  .hw_dplus_pullup(hw_dplus_pullup), .hw_dplus_pulldown(hw_dplus_pulldown),
  .dplus_pullup_en(dplus_pullup_en), .dplus_pulldown_en(dplus_pulldown_en),
  .vbus_power_on(vbus_power_on), .vbus_charge_en(vbus_charge_en),
  .vbus_discharge_en(vbus_discharge_en), .otg_irq(otg_irq)
);

// file: dv/uoc_pins_model.sv
// Far side: cable ID pin, line state and VBUS comparators.
// Assumes VBUS ramps over many clocks, so comparators lag.
`timescale 1ns/10ps
module uoc_pins_model (
  // Clock, reset and scenario
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       a_cable,
  input  wire [1:0] line_state,
  // Controls and pins
  input  wire       vbus_power_on,
  input  wire       vbus_charge_en,
  output wire       cable_id_pin,
  output wire       line_se0_in,
  output wire       line_j_indication,
  output wire       session_valid_in,
  output wire       session_end_in,
  output wire       a_vbus_valid_in
);
  reg [3:0] lvl;
  // Slow ramp: the block must not expect the comparators at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      lvl <= 4'h0;
    else if ((vbus_power_on || vbus_charge_en) && lvl != 4'hf)
      lvl <= lvl + 4'h1;
    else if (!vbus_power_on && !vbus_charge_en && lvl != 4'h0)
      lvl <= lvl - 4'h1;
  end
  assign cable_id_pin = !a_cable;
  assign line_se0_in = line_state[1];
  assign line_j_indication = line_state[0];
  assign session_valid_in = lvl[3];
  assign session_end_in = !lvl[3];
  assign a_vbus_valid_in = lvl[3];
endmodule // uoc_pins_model

// file: dv/usb_otg_enable_status_control_test.sv
// Self-checking bench for the OTG register block.
// Assumes the checker is bound in and MS_CYCLES shortened to 50.
`timescale 1ns/10ps
module usb_otg_enable_status_control_test;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [3:0]  hw;
  reg         a_cable;
  reg  [1:0]  line;
  reg  [15:0] s;
  reg  [31:0] r;
  integer     num_errors;
  integer     checks_done;
  integer     cyc;
  integer     i;
  wire        hready;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        id_p, se0, jst, sv, se, vv;
  wire        dpu, dmu, dpd, dmd, von, chg, dis, otg_irq;

  uoc_regs #(.MS_CYCLES(50)) uoc_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .cable_id_pin(id_p), .line_se0_in(se0),
    .line_j_indication(jst), .session_valid_in(sv), .session_end_in(se), .a_vbus_valid_in(vv),
    .hw_dplus_pullup(hw[3]), .hw_dminus_pullup(hw[2]), .hw_dplus_pulldown(hw[1]),
    .hw_dminus_pulldown(hw[0]), .dplus_pullup_en(dpu), .dminus_pullup_en(dmu),
    .dplus_pulldown_en(dpd), .dminus_pulldown_en(dmd), .vbus_power_on(von),
    .vbus_charge_en(chg), .vbus_discharge_en(dis), .otg_irq(otg_irq));
  uoc_pins_model uoc_pins_model_inst (
    .hclk(hclk), .hresetn(hresetn), .a_cable(a_cable), .line_state(line),
    .vbus_power_on(von), .vbus_charge_en(chg), .cable_id_pin(id_p), .line_se0_in(se0),
    .line_j_indication(jst), .session_valid_in(sv), .session_end_in(se), .a_vbus_valid_in(vv));
  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Pin outputs: software pulls only while bit 2 is set
  function [31:0] exp_out(input [7:0] c, input [3:0] h);
    exp_out = {25'h0, c[2] ? c[7:4] : h, c[3], c[1], c[0]};
  endfunction
  function [31:0] exp_stat(input cid, input stable, input vb);
    exp_stat = {24'h0, cid, 1'b0, stable, 1'b0, vb, !vb, 1'b0, vb};
  endfunction
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One single transfer: address phase, then data phase
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      r = hrdata;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(r, e);
    end
  endtask
  task wait_chk(input integer n, input [31:0] e);
    begin
      repeat (n) @(posedge hclk);
      #1 chk({31'h0, otg_irq}, e);
      // Back on an edge so the next stimulus lands on one
      @(posedge hclk);
    end
  endtask
  // Hang guard
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end

  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hw, a_cable, line, hresetn} = 0;
    num_errors = 0;
    checks_done = 0;
    cyc = 0;
    s = 16'h0049;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h10, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h44, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      s = lfsr(s);
      bus(1'b1, 8'h10, {s, s});
      rd(8'h10, {24'h0, s[7:0] & 8'hfd});
      s = lfsr(s);
      hw <= s[11:8];
      bus(1'b1, 8'h30, {s, s});
      rd(8'h30, {24'h0, s[7:0]});
      repeat (2) @(posedge hclk);
      #1 chk({25'h0, dpu, dmu, dpd, dmd, von, chg, dis}, exp_out(s[7:0], hw));
    end
    // Pins change only on a clock edge
    @(posedge hclk);
    a_cable <= 1'b1;
    line <= 2'h1;
    bus(1'b1, 8'h30, 32'h08);
    repeat (80) @(posedge hclk);
    rd(8'h20, exp_stat(1'b0, 1'b1, 1'b1));
    line <= 2'h2;
    repeat (5) @(posedge hclk);
    rd(8'h20, exp_stat(1'b0, 1'b0, 1'b1));
    a_cable <= 1'b0;
    bus(1'b1, 8'h30, 32'h01);
    repeat (80) @(posedge hclk);
    rd(8'h20, exp_stat(1'b1, 1'b1, 1'b0));
    bus(1'b1, 8'h00, 32'hff);
    bus(1'b1, 8'h10, 32'h80);
    wait_chk(2, 32'h0);
    a_cable <= 1'b1;
    wait_chk(8, 32'h1);
    bus(1'b1, 8'h00, 32'h80);
    wait_chk(2, 32'h0);
    bus(1'b1, 8'h10, 32'h40);
    wait_chk(60, 32'h1);
    // Line event: a new stable state raises it, a return to the old one does not
    bus(1'b1, 8'h00, 32'hff);
    bus(1'b1, 8'h10, 32'h20);
    wait_chk(2, 32'h0);
    line <= 2'h1;
    wait_chk(70, 32'h1);
    bus(1'b1, 8'h00, 32'hff);
    line <= 2'h0;
    repeat (5) @(posedge hclk);
    line <= 2'h1;
    wait_chk(70, 32'h0);
    // Activity event only through its own enable
    bus(1'b1, 8'h00, 32'hff);
    bus(1'b1, 8'h10, 32'h10);
    wait_chk(2, 32'h0);
    a_cable <= 1'b0;
    wait_chk(8, 32'h1);
    // Session comparators follow the VBUS ramp
    bus(1'b1, 8'h00, 32'hff);
    bus(1'b1, 8'h10, 32'h0c);
    wait_chk(2, 32'h0);
    bus(1'b1, 8'h30, 32'h08);
    wait_chk(20, 32'h1);
    bus(1'b1, 8'h00, 32'hff);
    bus(1'b1, 8'h10, 32'h01);
    wait_chk(2, 32'h0);
    bus(1'b1, 8'h30, 32'h00);
    wait_chk(20, 32'h1);
    rd(8'h20, exp_stat(1'b1, 1'b1, 1'b0));
    print_verdict;
  end
endmodule // usb_otg_enable_status_control_test
